/* File: common/tps_map.vh */
// Register map, field positions, reset values and bus constants of the touch power/status bank
`ifndef TPS_MAP_VH
`define TPS_MAP_VH

// Register offsets
`define TPS_ADDR_MAIN_CONTROL   8'h00
`define TPS_ADDR_GENERAL_STATUS 8'h02
`define TPS_ADDR_TOUCH_STATUS   8'h03
`define TPS_ADDR_NOISE_FLAGS    8'h0A

// Reset values and the value read from an unmapped address
`define TPS_RST_MAIN_CONTROL    8'h00
`define TPS_RST_GENERAL_STATUS  8'h00
`define TPS_RST_TOUCH_STATUS    8'h00
`define TPS_RST_NOISE_FLAGS     8'h00
`define TPS_READ_UNMAPPED       8'h00

// Main control fields
`define TPS_MC_STANDBY_BIT      5
`define TPS_MC_DEEP_SLEEP_BIT   4
`define TPS_MC_INT_BIT          0

// General status fields
`define TPS_GS_BASE_LIMIT_BIT   6
`define TPS_GS_CAL_FAIL_BIT     5
`define TPS_GS_PWR_HELD_BIT     4
`define TPS_GS_MULTI_BLOCK_BIT  2
`define TPS_GS_PATTERN_BIT      1
`define TPS_GS_TOUCH_BIT        0

// Number of sensor inputs
`define TPS_NUM_INPUTS          6

// Seven-bit bus address, arbitrary value
`define TPS_DEV_ADDR            7'h2A

`endif

/* File: logic/tps_input_cell.v */
// Per-input latched touch status with interrupt-request generation
`timescale 1ns/10ps

module tps_input_cell (
    input  wire ref_clk,
    input  wire reset,
    input  wire touch_now,
    input  wire int_enable,
    input  wire clear_req,
    input  wire wipe,
    output reg  touch_flag,
    output wire raise_int
);

    reg touch_prev;

    // Only a fresh touch on an enabled input asks for an interrupt
    assign raise_int = touch_now & ~touch_prev & int_enable;

    always @(posedge ref_clk) begin
        if (reset || wipe) begin
            touch_flag <= 1'b0;
            touch_prev <= 1'b0;
        end else begin
            touch_prev <= touch_now;
            // A touch still present keeps the bit; set wins over clear
            if (touch_now)
                touch_flag <= 1'b1;
            else if (clear_req)
                touch_flag <= 1'b0;
        end
    end

endmodule

/* File: logic/tps_bus_slave.v */
// Two-wire serial register port: address, pointer byte, byte writes and byte reads
`timescale 1ns/10ps
`include "tps_map.vh"

module tps_bus_slave (
    input  wire       ref_clk,
    input  wire       reset,
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    output reg        wr_stb,
    output reg        rd_stb,
    output reg  [7:0] reg_addr,
    output reg  [7:0] wr_data,
    input  wire [7:0] rd_data
);

    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ADDR = 7'h02;
    localparam [6:0] S_PTR  = 7'h04;
    localparam [6:0] S_WDAT = 7'h08;
    localparam [6:0] S_RDAT = 7'h10;
    localparam [6:0] S_ACK  = 7'h20;
    localparam [6:0] S_RACK = 7'h40;

    reg       scl_q;
    reg       sda_q;
    reg [6:0] state;
    reg [6:0] after_ack;
    reg [7:0] shift;
    reg [3:0] cnt;

    wire start_c = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_c  = scl_in & scl_q & ~sda_q & sda_in;
    wire rise    = scl_in & ~scl_q;
    wire fall    = ~scl_in & scl_q;

    always @(posedge ref_clk) begin
        if (reset) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            sda_out   <= 1'b0;
            sda_oe    <= 1'b0;
            wr_stb    <= 1'b0;
            rd_stb    <= 1'b0;
            reg_addr  <= 8'h00;
            wr_data   <= 8'h00;
            state     <= S_IDLE;
            after_ack <= S_IDLE;
            shift     <= 8'h00;
            cnt       <= 4'h0;
        end else begin
            scl_q   <= scl_in;
            sda_q   <= sda_in;
            sda_out <= 1'b0;
            wr_stb  <= 1'b0;
            rd_stb  <= 1'b0;
            if (start_c) begin
                state  <= S_ADDR;
                cnt    <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state  <= S_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    S_ADDR, S_PTR, S_WDAT: begin
                        if (rise && cnt != 4'h8) begin
                            shift <= {shift[6:0], sda_in};
                            cnt   <= cnt + 4'h1;
                        end else if (fall && cnt == 4'h8) begin
                            cnt <= 4'h0;
                            if (state == S_ADDR) begin
                                if (shift[7:1] == `TPS_DEV_ADDR) begin
                                    sda_oe    <= 1'b1;
                                    state     <= S_ACK;
                                    after_ack <= shift[0] ? S_RDAT : S_PTR;
                                end else begin
                                    state <= S_IDLE;
                                end
                            end else if (state == S_PTR) begin
                                reg_addr  <= shift;
                                sda_oe    <= 1'b1;
                                state     <= S_ACK;
                                after_ack <= S_WDAT;
                            end else begin
                                wr_data   <= shift;
                                wr_stb    <= 1'b1;
                                sda_oe    <= 1'b1;
                                state     <= S_ACK;
                                after_ack <= S_WDAT;
                            end
                        end
                    end
                    S_ACK: begin
                        if (fall) begin
                            state <= after_ack;
                            if (after_ack == S_RDAT) begin
                                // Read data is sampled here; the bank sees rd_stb as the read
                                shift  <= rd_data;
                                sda_oe <= ~rd_data[7];
                                rd_stb <= 1'b1;
                                cnt    <= 4'h1;
                            end else begin
                                sda_oe <= 1'b0;
                                cnt    <= 4'h0;
                            end
                        end
                    end
                    S_RDAT: begin
                        if (fall) begin
                            if (cnt == 4'h8) begin
                                sda_oe <= 1'b0;
                                state  <= S_RACK;
                            end else begin
                                shift  <= {shift[6:0], 1'b0};
                                sda_oe <= ~shift[6];
                                cnt    <= cnt + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (rise)
                            state <= sda_in ? S_IDLE : S_ACK;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* File: logic/tps_touch_power_status.v */
// Power-state control and status register bank of a six-input touch controller
`timescale 1ns/10ps
`include "tps_map.vh"

module tps_touch_power_status (
    input  wire       ref_clk,
    input  wire       reset,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    input  wire [5:0] raw_touch,
    input  wire [5:0] touch_int_enable,
    input  wire [5:0] standby_select,
    input  wire [5:0] input_enabled,
    input  wire [5:0] base_count_out,
    input  wire [5:0] cal_fail,
    input  wire       power_button_held,
    input  wire       power_button_touch,
    input  wire       multi_touch_block,
    input  wire       pattern_hit,
    input  wire       pattern_alert_enable,
    input  wire       pattern_detect_enable,
    input  wire [5:0] raw_noise,
    input  wire [5:0] delta_over_pattern,
    output reg        alert_n,
    output reg  [5:0] scan_enable,
    output reg        low_power_state,
    output reg        deep_sleep_state,
    output reg  [5:0] delta_force_zero,
    output reg  [5:0] pattern_over_mask
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register port

    wire       wr_stb;
    wire       rd_stb;
    wire [7:0] reg_addr;
    wire [7:0] wr_data;
    reg  [7:0] rd_data;

    tps_bus_slave u_bus (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .wr_stb   (wr_stb),
        .rd_stb   (rd_stb),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .rd_data  (rd_data)
    );

    // Status registers whose read matters for standby retention
    function is_status;
        input [7:0] addr;
        begin
            is_status = (addr == `TPS_ADDR_GENERAL_STATUS) || (addr == `TPS_ADDR_TOUCH_STATUS);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Main control

    reg        low_power_scan_enable;
    reg        deepest_sleep_enable;
    reg        int_flag;
    reg        power_button_held_flag;
    reg        pattern_detected_flag;
    reg        base_count_limit_flag;
    reg        analog_cal_failure_flag;
    reg        multi_touch_block_flag;
    reg  [5:0] noise_flags;
    reg        pwr_held_prev;
    reg        pattern_prev;
    wire [5:0] touch_flags;
    wire [5:0] touch_raise;

    // Reset images, sliced per field so each register takes only its own bits
    wire [7:0] main_rst  = `TPS_RST_MAIN_CONTROL;
    wire [7:0] noise_rst = `TPS_RST_NOISE_FLAGS;

    wire wr_main     = wr_stb && (reg_addr == `TPS_ADDR_MAIN_CONTROL);
    wire next_sleep  = wr_main ? wr_data[`TPS_MC_DEEP_SLEEP_BIT] : deepest_sleep_enable;
    wire sleep_entry = next_sleep & ~deepest_sleep_enable;
    // Writing 1 to the flag is ignored: only hardware events set it
    wire int_clear   = wr_main && !wr_data[`TPS_MC_INT_BIT] && int_flag;
    // Standby keeps status until the host reads it
    wire std_read    = rd_stb && is_status(reg_addr) && low_power_scan_enable
                       && !deepest_sleep_enable;
    wire clear_req   = int_clear | std_read;

    // Deep sleep masks the standby bit entirely
    wire [5:0] next_scan = next_sleep ? 6'h00 :
        ((wr_main ? wr_data[`TPS_MC_STANDBY_BIT] : low_power_scan_enable)
         ? standby_select : 6'h3F);

    // Touches are only seen on inputs being sampled
    wire [5:0] touch_seen = raw_touch & scan_enable;

    wire pwr_event = power_button_held & ~pwr_held_prev & ~deepest_sleep_enable;
    wire pat_event = pattern_hit & ~pattern_prev & ~deepest_sleep_enable;

    wire int_event = (|touch_raise)
                     | pwr_event
                     | (pat_event & pattern_alert_enable);

    reg next_int;

    always @* begin
        next_int = int_flag;
        if (sleep_entry || next_sleep)
            next_int = 1'b0;
        else if (int_event)
            next_int = 1'b1; // Event wins over a clear in the same cycle
        else if (int_clear)
            next_int = 1'b0;
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            low_power_scan_enable <= main_rst[`TPS_MC_STANDBY_BIT];
            deepest_sleep_enable  <= 1'b0;
            int_flag              <= 1'b0;
            alert_n               <= 1'b1;
            scan_enable           <= 6'h3F;
            low_power_state       <= 1'b0;
            deep_sleep_state      <= 1'b0;
        end else begin
            if (wr_main) begin
                low_power_scan_enable <= wr_data[`TPS_MC_STANDBY_BIT];
                deepest_sleep_enable  <= wr_data[`TPS_MC_DEEP_SLEEP_BIT];
            end
            int_flag         <= next_int;
            alert_n          <= ~next_int;
            scan_enable      <= next_scan;
            low_power_state  <= ~next_sleep & (wr_main ? wr_data[`TPS_MC_STANDBY_BIT] : low_power_scan_enable);
            deep_sleep_state <= next_sleep;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-input touch status

    genvar gi;
    generate
        for (gi = 0; gi < `TPS_NUM_INPUTS; gi = gi + 1) begin : g_in
            tps_input_cell u_cell (
                .ref_clk    (ref_clk),
                .reset      (reset),
                .touch_now  (touch_seen[gi]),
                .int_enable (touch_int_enable[gi]),
                .clear_req  (clear_req),
                .wipe       (sleep_entry),
                .touch_flag (touch_flags[gi]),
                .raise_int  (touch_raise[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // General status, noise flags and pattern counting

    always @(posedge ref_clk) begin
        if (reset || sleep_entry) begin
            power_button_held_flag  <= 1'b0;
            pattern_detected_flag   <= 1'b0;
            base_count_limit_flag   <= 1'b0;
            analog_cal_failure_flag <= 1'b0;
            multi_touch_block_flag  <= 1'b0;
            noise_flags             <= noise_rst[5:0];
            pwr_held_prev           <= 1'b0;
            pattern_prev            <= 1'b0;
            delta_force_zero        <= 6'h00;
            pattern_over_mask       <= 6'h00;
        end else begin
            pwr_held_prev <= power_button_held;
            pattern_prev  <= pattern_hit;
            if (pwr_event)
                power_button_held_flag <= 1'b1;
            else if (clear_req && !power_button_touch)
                power_button_held_flag <= 1'b0;
            if (pat_event)
                pattern_detected_flag <= 1'b1;
            else if (clear_req && !pattern_hit)
                pattern_detected_flag <= 1'b0;
            // Limit and calibration flags hold only while a cause remains on an enabled input
            base_count_limit_flag   <= ~deepest_sleep_enable & |(base_count_out & input_enabled);
            analog_cal_failure_flag <= ~deepest_sleep_enable & |(cal_fail & input_enabled);
            multi_touch_block_flag  <= ~deepest_sleep_enable & multi_touch_block;
            noise_flags             <= deepest_sleep_enable ? 6'h00 : raw_noise;
            delta_force_zero        <= deepest_sleep_enable ? 6'h00 : raw_noise;
            // OR merges the two causes so an input is counted once
            pattern_over_mask <= pattern_detect_enable ? (delta_over_pattern | raw_noise)
                                                       : delta_over_pattern;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux

    always @* begin
        case (reg_addr)
            `TPS_ADDR_MAIN_CONTROL:
                rd_data = {2'b00, low_power_scan_enable, deepest_sleep_enable, 3'b000, int_flag};
            `TPS_ADDR_GENERAL_STATUS:
                rd_data = {1'b0, base_count_limit_flag, analog_cal_failure_flag, power_button_held_flag,
                           1'b0, multi_touch_block_flag, pattern_detected_flag, |touch_flags};
            `TPS_ADDR_TOUCH_STATUS:
                rd_data = {2'b00, touch_flags};
            `TPS_ADDR_NOISE_FLAGS:
                rd_data = {2'b00, noise_flags};
            default:
                rd_data = `TPS_READ_UNMAPPED;
        endcase
    end

endmodule

/* File: verif/tps_props.sv */
// Concurrent checks on the ports of the touch power/status register bank
`timescale 1ns/10ps

module tps_props (
    input wire       ref_clk,
    input wire       reset,
    input wire [5:0] raw_touch,
    input wire [5:0] touch_int_enable,
    input wire [5:0] standby_select,
    input wire       power_button_held,
    input wire       pattern_hit,
    input wire       pattern_alert_enable,
    input wire       pattern_detect_enable,
    input wire [5:0] raw_noise,
    input wire [5:0] delta_over_pattern,
    input wire       alert_n,
    input wire [5:0] scan_enable,
    input wire       low_power_state,
    input wire       deep_sleep_state,
    input wire [5:0] delta_force_zero,
    input wire [5:0] pattern_over_mask
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence touch_event_s;
        (|(raw_touch & ~$past(raw_touch) & touch_int_enable & scan_enable)) && !deep_sleep_state;
    endsequence

    // Alert is registered once behind a combinational event; allow one or two edges
    sequence alert_soon_s;
        ##[1:2] !alert_n;
    endsequence

    touch_alert_a: assert property (touch_event_s |-> alert_soon_s)
        else $error("enabled touch did not pull alert low");
    power_alert_a: assert property ($rose(power_button_held) && !deep_sleep_state |-> alert_soon_s)
        else $error("power button hold did not pull alert low");
    pattern_alert_a: assert property ($rose(pattern_hit) && pattern_alert_enable && !deep_sleep_state
        |-> alert_soon_s)
        else $error("pattern alert did not pull alert low");
    quiet_alert_a: assert property (alert_n && !power_button_held && !pattern_hit && touch_int_enable == 6'h00
        && $past(touch_int_enable) == 6'h00 |=> alert_n)
        else $error("alert asserted with every source disabled");
    sleep_state_a: assert property (deep_sleep_state && $past(deep_sleep_state)
        |-> scan_enable == 6'h00 && !low_power_state && alert_n)
        else $error("deep sleep still scanning or alerting");
    standby_scan_a: assert property (low_power_state && $past(low_power_state)
        |-> scan_enable == $past(standby_select))
        else $error("standby scan set differs from standby selection");
    noise_follow_a: assert property (!$past(reset) |-> delta_force_zero ==
        ((deep_sleep_state || $past(deep_sleep_state)) ? 6'h00 : $past(raw_noise)))
        else $error("delta force zero does not follow noise");
    pattern_once_a: assert property (!$past(reset) && $past(pattern_detect_enable) && !$rose(deep_sleep_state)
        |-> pattern_over_mask == ($past(raw_noise) | $past(delta_over_pattern)))
        else $error("pattern count mask wrong");
endmodule

bind tps_touch_power_status tps_props tps_props_inst (
    .ref_clk(ref_clk), .reset(reset), .raw_touch(raw_touch), .touch_int_enable(touch_int_enable),
    .standby_select(standby_select), .power_button_held(power_button_held), .pattern_hit(pattern_hit),
    .pattern_alert_enable(pattern_alert_enable), .pattern_detect_enable(pattern_detect_enable),
    .raw_noise(raw_noise), .delta_over_pattern(delta_over_pattern), .alert_n(alert_n),
    .scan_enable(scan_enable), .low_power_state(low_power_state), .deep_sleep_state(deep_sleep_state),
    .delta_force_zero(delta_force_zero), .pattern_over_mask(pattern_over_mask)
);

/* File: verif/tps_host_model.sv */
// Bus host model: single-byte register writes and reads over the two-wire port
`timescale 1ns/10ps
`include "tps_map.vh"

module tps_host_model (
    input  wire ref_clk,
    input  wire sda,
    output reg  scl,
    output reg  sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Three core cycles per step keeps every SCL phase well above the sync delay
    task automatic step;
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic put_bit(input logic b);
        sda_low = !b;
        step;
        scl = 1'b1;
        step;
        scl = 1'b0;
        step;
    endtask

    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        step;
        scl = 1'b1;
        step;
        b = sda;
        scl = 1'b0;
        step;
    endtask

    task automatic start_cond;
        sda_low = 1'b0;
        step;
        scl = 1'b1;
        step;
        sda_low = 1'b1;
        step;
        scl = 1'b0;
        step;
    endtask

    task automatic stop_cond;
        sda_low = 1'b1;
        step;
        scl = 1'b1;
        step;
        sda_low = 1'b0;
        step;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        get_bit(a);
        ack = !a;
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, output logic ok);
        logic a1, a2, a3;
        start_cond;
        send_byte({`TPS_DEV_ADDR, 1'b0}, a1);
        send_byte(addr, a2);
        send_byte(data, a3);
        stop_cond;
        ok = a1 & a2 & a3;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        logic a1, a2, a3, b;
        start_cond;
        send_byte({`TPS_DEV_ADDR, 1'b0}, a1);
        send_byte(addr, a2);
        start_cond;
        send_byte({`TPS_DEV_ADDR, 1'b1}, a3);
        for (int i = 0; i < 8; i++) begin
            get_bit(b);
            data = {data[6:0], b};
        end
        put_bit(1'b1);
        stop_cond;
        ok = a1 & a2 & a3;
    endtask
endmodule

/* File: verif/touch_power_status_regs_test.sv */
// Self-checking bench for the touch power/status register bank
`timescale 1ns/10ps
`include "tps_map.vh"

module touch_power_status_regs_test;
    typedef struct packed {
        logic [5:0] noise, over, bco, calf, en;
        logic [7:0] nf, gs;
        logic [5:0] mask;
    } tps_row_t;

    reg        ref_clk = 1'b0;
    reg        reset = 1'b1;
    reg  [5:0] raw_touch = 6'h00, touch_int_enable = 6'h3F, standby_select = 6'h00, input_enabled = 6'h3F;
    reg  [5:0] base_count_out = 6'h00, cal_fail = 6'h00, raw_noise = 6'h00, delta_over_pattern = 6'h00;
    reg        power_button_held = 1'b0, power_button_touch = 1'b0, multi_touch_block = 1'b0;
    reg        pattern_hit = 1'b0, pattern_alert_enable = 1'b0, pattern_detect_enable = 1'b1;
    wire       scl, sda_low, sda_out, sda_oe, alert_n, low_power_state, deep_sleep_state;
    wire [5:0] scan_enable, delta_force_zero, pattern_over_mask;
    wire       sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
    int        fail_count = 0;
    int        checks = 0;
    // The third row puts a limit fault on disabled input 0 to prove it is masked; its calibration fault also reaches enabled input 1
    tps_row_t  rows [4] = '{'{6'h00, 6'h00, 6'h00, 6'h00, 6'h3F, 8'h00, 8'h00, 6'h00},
                          '{6'h05, 6'h0C, 6'h01, 6'h00, 6'h3F, 8'h05, 8'h40, 6'h0D},
                          '{6'h00, 6'h21, 6'h01, 6'h03, 6'h3E, 8'h00, 8'h20, 6'h21},
                          '{6'h3F, 6'h00, 6'h00, 6'h00, 6'h3F, 8'h3F, 8'h00, 6'h3F}};

    always #5 ref_clk = ~ref_clk;

    tps_touch_power_status tps_touch_power_status_inst (
        .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .raw_touch(raw_touch), .touch_int_enable(touch_int_enable), .standby_select(standby_select),
        .input_enabled(input_enabled), .base_count_out(base_count_out), .cal_fail(cal_fail),
        .power_button_held(power_button_held), .power_button_touch(power_button_touch),
        .multi_touch_block(multi_touch_block), .pattern_hit(pattern_hit),
        .pattern_alert_enable(pattern_alert_enable), .pattern_detect_enable(pattern_detect_enable),
        .raw_noise(raw_noise), .delta_over_pattern(delta_over_pattern), .alert_n(alert_n),
        .scan_enable(scan_enable), .low_power_state(low_power_state), .deep_sleep_state(deep_sleep_state),
        .delta_force_zero(delta_force_zero), .pattern_over_mask(pattern_over_mask));

    tps_host_model tps_host_model_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        tps_host_model_inst.write_reg(a, d, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic ok;
        logic [7:0] d;
        tps_host_model_inst.read_reg(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d & m, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic stop_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(60000);
        fail_count++;
        stop_test;
    end

    initial begin
        cyc(4);
        reset = 1'b0;
        cyc(2);
        foreach (rows[i]) begin
            raw_noise = rows[i].noise;
            delta_over_pattern = rows[i].over;
            base_count_out = rows[i].bco;
            cal_fail = rows[i].calf;
            input_enabled = rows[i].en;
            cyc(3);
            check({2'b00, delta_force_zero}, {2'b00, rows[i].noise});
            check({2'b00, pattern_over_mask}, {2'b00, rows[i].mask});
            rd(`TPS_ADDR_NOISE_FLAGS, 8'hFF, rows[i].nf);
            rd(`TPS_ADDR_GENERAL_STATUS, 8'h60, rows[i].gs);
        end
        // With pattern detection off, noise no longer counts toward the mask
        pattern_detect_enable = 1'b0;
        cyc(3);
        check({2'b00, pattern_over_mask}, 8'h00);
        pattern_detect_enable = 1'b1;
        raw_noise = 6'h00;
        raw_touch = 6'h24;
        cyc(4);
        check({7'h00, alert_n}, 8'h00);
        rd(`TPS_ADDR_TOUCH_STATUS, 8'hFF, 8'h24);
        rd(`TPS_ADDR_GENERAL_STATUS, 8'h01, 8'h01);
        raw_touch = 6'h20;
        wr(`TPS_ADDR_MAIN_CONTROL, 8'h00);
        cyc(2);
        check({7'h00, alert_n}, 8'h01);
        rd(`TPS_ADDR_TOUCH_STATUS, 8'hFF, 8'h20);
        check({7'h00, alert_n}, 8'h01);
        touch_int_enable = 6'h00;
        raw_touch = 6'h21;
        multi_touch_block = 1'b1;
        cyc(4);
        check({7'h00, alert_n}, 8'h01);
        rd(`TPS_ADDR_GENERAL_STATUS, 8'h04, 8'h04);
        check({7'h00, alert_n}, 8'h01);
        multi_touch_block = 1'b0;
        power_button_touch = 1'b1;
        power_button_held = 1'b1;
        cyc(4);
        check({7'h00, alert_n}, 8'h00);
        power_button_held = 1'b0;
        wr(`TPS_ADDR_MAIN_CONTROL, 8'h00);
        rd(`TPS_ADDR_GENERAL_STATUS, 8'h10, 8'h10);
        power_button_touch = 1'b0;
        pattern_hit = 1'b1;
        cyc(4);
        check({7'h00, alert_n}, 8'h01);
        rd(`TPS_ADDR_GENERAL_STATUS, 8'h02, 8'h02);
        pattern_hit = 1'b0;
        pattern_alert_enable = 1'b1;
        cyc(2);
        pattern_hit = 1'b1;
        cyc(4);
        check({7'h00, alert_n}, 8'h00);
        pattern_hit = 1'b0;
        wr(`TPS_ADDR_MAIN_CONTROL, 8'h00);
        rd(`TPS_ADDR_GENERAL_STATUS, 8'h12, 8'h00);
        standby_select = 6'h05;
        touch_int_enable = 6'h3F;
        raw_touch = 6'h00;
        wr(`TPS_ADDR_MAIN_CONTROL, 8'hEE);
        cyc(2);
        check({1'b0, low_power_state, scan_enable}, 8'h45);
        rd(`TPS_ADDR_MAIN_CONTROL, 8'hFF, 8'h20);
        // Stale bits of inputs 0 and 5 survive into standby until read, then go
        rd(`TPS_ADDR_TOUCH_STATUS, 8'hFF, 8'h21);
        rd(`TPS_ADDR_TOUCH_STATUS, 8'hFF, 8'h00);
        raw_touch = 6'h01;
        cyc(4);
        check({7'h00, alert_n}, 8'h00);
        wr(`TPS_ADDR_MAIN_CONTROL, 8'h30);
        cyc(2);
        check({deep_sleep_state, low_power_state, scan_enable}, 8'h80);
        check({7'h00, alert_n}, 8'h01);
        rd(`TPS_ADDR_GENERAL_STATUS, 8'hFF, 8'h00);
        rd(`TPS_ADDR_TOUCH_STATUS, 8'hFF, 8'h00);
        rd(`TPS_ADDR_MAIN_CONTROL, 8'hFF, 8'h30);
        // A live touch across reset would look like a fresh event afterwards
        raw_touch = 6'h00;
        reset = 1'b1;
        cyc(3);
        reset = 1'b0;
        cyc(2);
        check({deep_sleep_state, low_power_state, scan_enable}, 8'h3F);
        check({7'h00, alert_n}, 8'h01);
        rd(`TPS_ADDR_MAIN_CONTROL, 8'hFF, 8'h00);
        rd(8'h05, 8'hFF, 8'h00);
        stop_test;
    end
endmodule
